// ===== include/psps_defs.vh
// Constants for the supply-on request previous state sampler.
`ifndef PSPS_DEFS_VH
`define PSPS_DEFS_VH

// Register indexes; the byte address is four times the index.
`define PSPS_SEL_IDX        10'h053
`define PSPS_STAT_IDX       10'h070

// Select register layout and reset value.
`define PSPS_SEL_RESET      4'h0
`define PSPS_SEL_CODE_MSB   2
`define PSPS_SEL_RSVD_BIT   3

// Status register layout.
`define PSPS_STAT_STBY_BIT  8
`define PSPS_STAT_MAIN_BIT  9
`define PSPS_STAT_PREV_BIT  10
`define PSPS_STAT_FAIL_BIT  11

// Sampling period.
`define PSPS_HALF_SEC_MS    500
`define PSPS_CLK_MHZ        250
`define PSPS_HALF_SEC_CYC   (`PSPS_HALF_SEC_MS * 1000 * `PSPS_CLK_MHZ)

// History depth.
`define PSPS_HIST_DEPTH     8

// Bus responses.
`define PSPS_RESP_OKAY      2'h0
`define PSPS_RESP_SLVERR    2'h2

`endif

// ===== hdl/psps_tick.v
// Half-second sampling tick generator for the previous state sampler.
`timescale 1ns/1ps
module psps_tick #(
  parameter CYCLES = 125000000,
  parameter CNT_W  = 27
) (
  // Clock and reset
  input  wire aclk,
  input  wire aresetn,
  // Control and tick
  input  wire run,
  output reg  tick
);

  reg [CNT_W-1:0] count;

  // The count restarts whenever run drops, so the first capture after the rails
  // come up lands one full period later rather than at a stale phase.
  always @(posedge aclk) begin
    if (!aresetn) begin
      count <= {CNT_W{1'b0}};
      tick  <= 1'b0;
    end else if (!run) begin
      count <= {CNT_W{1'b0}};
      tick  <= 1'b0;
    end else if (count == CYCLES[CNT_W-1:0] - 1'b1) begin
      count <= {CNT_W{1'b0}};
      tick  <= 1'b1;
    end else begin
      count <= count + 1'b1;
      tick  <= 1'b0;
    end
  end

endmodule // psps_tick

// ===== hdl/psps_hist_sel.v
// History entry selector: picks the capture named by the select code.
`timescale 1ns/1ps
module psps_hist_sel #(
  parameter DEPTH = 8,
  parameter SEL_W = 3
) (
  // History and code
  input  wire [DEPTH-1:0] history,
  input  wire [SEL_W-1:0] code,
  // Selected entry
  output wire             entry
);

  // Entry 0 is the newest capture, entry DEPTH-1 the oldest.
  assign entry = history[code];

endmodule // psps_hist_sel

// ===== hdl/psps_sampler.v
// Supply-on request previous state sampler with AXI4-Lite register access.
`timescale 1ns/1ps
`include "psps_defs.vh"
module psps_sampler #(
  parameter HALF_SEC_CYCLES = `PSPS_HALF_SEC_CYC,
  parameter ADDR_W          = 12
) (
  // Clock and reset
  input  wire              aclk,
  input  wire              aresetn,
  // AXI4-Lite write address
  input  wire [ADDR_W-1:0] s_axi_awaddr,
  input  wire [2:0]        s_axi_awprot,
  input  wire              s_axi_awvalid,
  output reg               s_axi_awready,
  // AXI4-Lite write data
  input  wire [31:0]       s_axi_wdata,
  input  wire [3:0]        s_axi_wstrb,
  input  wire              s_axi_wvalid,
  output reg               s_axi_wready,
  // AXI4-Lite write response
  output reg  [1:0]        s_axi_bresp,
  output reg               s_axi_bvalid,
  input  wire              s_axi_bready,
  // AXI4-Lite read address
  input  wire [ADDR_W-1:0] s_axi_araddr,
  input  wire [2:0]        s_axi_arprot,
  input  wire              s_axi_arvalid,
  output reg               s_axi_arready,
  // AXI4-Lite read data
  output reg  [31:0]       s_axi_rdata,
  output reg  [1:0]        s_axi_rresp,
  output reg               s_axi_rvalid,
  input  wire              s_axi_rready,
  // Supply pin and rail monitors
  input  wire              supply_on_request_pin,
  input  wire              standby_rail_ok,
  input  wire              main_rail_ok,
  // Power-failure recovery interface
  output reg               prev_state,
  output reg               prev_state_valid
);

  localparam DEPTH = `PSPS_HIST_DEPTH;
  localparam SEL_W = `PSPS_SEL_CODE_MSB + 1;

  // Select register (bits 3:0 stored, 7:4 read zero).
  reg  [3:0]        sel_reg;
  // Capture history, entry 0 newest.
  reg  [DEPTH-1:0]  history;
  // Rail state seen last cycle, for edge detection.
  reg               stby_prev;
  // Sticky failure flag, cleared by writing one from software.
  reg               fail_seen;
  // Captured previous state, held across the outage.
  reg               frozen_state;

  // Write channel holding registers.
  reg               aw_held;
  reg  [ADDR_W-1:0] aw_addr;
  reg               w_held;
  reg  [31:0]       w_data;
  reg  [3:0]        w_strb;

  wire              rails_up;
  wire              tick;
  wire              sel_entry;
  wire              fail_event;
  wire              return_event;
  wire              do_write;
  wire              wr_sel_hit;
  wire              wr_stat_hit;
  wire              rd_sel_hit;
  wire              rd_stat_hit;
  wire [31:0]       stat_word;
  wire              fail_clear;

  assign rails_up     = standby_rail_ok & main_rail_ok;
  assign fail_event   = stby_prev & ~standby_rail_ok;
  assign return_event = ~stby_prev & standby_rail_ok;

  psps_tick #(
    .CYCLES (HALF_SEC_CYCLES),
    .CNT_W  (32)
  ) u_tick (
    .aclk    (aclk),
    .aresetn (aresetn),
    .run     (rails_up),
    .tick    (tick)
  );

  psps_hist_sel #(
    .DEPTH (DEPTH),
    .SEL_W (SEL_W)
  ) u_sel (
    .history (history),
    .code    (sel_reg[`PSPS_SEL_CODE_MSB:0]),
    .entry   (sel_entry)
  );

  // History shifts only on a tick, and the tick only runs with both rails up,
  // so a collapsing rail leaves the last eight captures untouched.
  always @(posedge aclk) begin
    if (!aresetn) begin
      history <= {DEPTH{1'b0}};
    end else if (tick && rails_up) begin
      history <= {history[DEPTH-2:0], supply_on_request_pin};
    end
  end

  // Failure and recovery tracking.
  always @(posedge aclk) begin
    if (!aresetn) begin
      stby_prev        <= 1'b0;
      frozen_state     <= 1'b0;
      prev_state       <= 1'b0;
      prev_state_valid <= 1'b0;
      fail_seen        <= 1'b0;
    end else begin
      stby_prev <= standby_rail_ok;
      if (fail_event) begin
        frozen_state     <= sel_entry;
        prev_state_valid <= 1'b0;
      end else if (return_event) begin
        prev_state       <= frozen_state;
        prev_state_valid <= fail_seen | 1'b0;
      end
      // A new failure in the same cycle as a software clear is kept.
      if (fail_event) begin
        fail_seen <= 1'b1;
      end else if (fail_clear) begin
        fail_seen <= 1'b0;
      end
    end
  end

  // Write path: address and data are taken in either order, then committed.
  assign do_write    = aw_held & w_held & ~s_axi_bvalid;
  assign wr_sel_hit  = (aw_addr[ADDR_W-1:2] == `PSPS_SEL_IDX);
  assign wr_stat_hit = (aw_addr[ADDR_W-1:2] == `PSPS_STAT_IDX);
  assign fail_clear  = do_write & wr_stat_hit & w_strb[1] & w_data[`PSPS_STAT_FAIL_BIT];

  always @(posedge aclk) begin
    if (!aresetn) begin
      aw_held       <= 1'b0;
      aw_addr       <= {ADDR_W{1'b0}};
      w_held        <= 1'b0;
      w_data        <= 32'h00000000;
      w_strb        <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `PSPS_RESP_OKAY;
      sel_reg       <= `PSPS_SEL_RESET;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held       <= 1'b1;
        aw_addr       <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end else if (!aw_held) begin
        s_axi_awready <= 1'b1;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held       <= 1'b1;
        w_data       <= s_axi_wdata;
        w_strb       <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end else if (!w_held) begin
        s_axi_wready <= 1'b1;
      end
      if (do_write) begin
        aw_held      <= 1'b0;
        w_held       <= 1'b0;
        s_axi_bvalid <= 1'b1;
        if (wr_sel_hit) begin
          // Bit 3 is stored as written; software is expected to keep it zero.
          if (w_strb[0]) begin
            sel_reg <= w_data[3:0];
          end
          s_axi_bresp <= `PSPS_RESP_OKAY;
        end else if (wr_stat_hit) begin
          s_axi_bresp <= `PSPS_RESP_OKAY;
        end else begin
          s_axi_bresp <= `PSPS_RESP_SLVERR;
        end
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Read path.
  assign rd_sel_hit  = (s_axi_araddr[ADDR_W-1:2] == `PSPS_SEL_IDX);
  assign rd_stat_hit = (s_axi_araddr[ADDR_W-1:2] == `PSPS_STAT_IDX);
  assign stat_word   = {20'h00000, fail_seen, frozen_state, main_rail_ok,
                        standby_rail_ok, history};

  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h00000000;
      s_axi_rresp   <= `PSPS_RESP_OKAY;
    end else begin
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid  <= 1'b1;
        if (rd_sel_hit) begin
          s_axi_rdata <= {28'h0000000, sel_reg};
          s_axi_rresp <= `PSPS_RESP_OKAY;
        end else if (rd_stat_hit) begin
          s_axi_rdata <= stat_word;
          s_axi_rresp <= `PSPS_RESP_OKAY;
        end else begin
          s_axi_rdata <= 32'h00000000;
          s_axi_rresp <= `PSPS_RESP_SLVERR;
        end
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid  <= 1'b0;
        s_axi_arready <= 1'b1;
      end else if (!s_axi_rvalid) begin
        s_axi_arready <= 1'b1;
      end
    end
  end

endmodule // psps_sampler

// ===== test/psps_sampler_monitor.sv
// Port checker for the previous state sampler.
`timescale 1ns/1ps
module psps_sampler_monitor #(
  parameter ADDR_W = 12
) (
  // Clock and reset
  input wire              aclk,
  input wire              aresetn,
  // Register bus
  input wire [ADDR_W-1:0] s_axi_araddr,
  input wire              s_axi_arvalid,
  input wire              s_axi_arready,
  input wire [31:0]       s_axi_rdata,
  input wire              s_axi_rvalid,
  input wire              s_axi_bvalid,
  input wire              s_axi_bready,
  input wire [1:0]        s_axi_bresp,
  // Rail and recovery
  input wire              standby_rail_ok,
  input wire              prev_state,
  input wire              prev_state_valid
);
  reg rd_sel;
  reg fell;
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  always @(posedge aclk) begin
    if (!aresetn) begin
      rd_sel <= 1'b0;
      fell   <= 1'b0;
    end else begin
      if (s_axi_arvalid && s_axi_arready) rd_sel <= s_axi_araddr == 'h14C;
      if ($fell(standby_rail_ok)) fell <= 1'b1;
    end
  end
  chk_sel_upper: assert property (s_axi_rvalid && rd_sel |-> s_axi_rdata[31:4] == 28'h0)
    else $error("select upper bits set");
  chk_fail_drop: assert property ($fell(standby_rail_ok) |=> !prev_state_valid)
    else $error("valid kept after failure");
  chk_ret_valid: assert property ($rose(standby_rail_ok) && fell |=> prev_state_valid)
    else $error("valid missing on return");
  chk_prev_hold: assert property (!$rose(standby_rail_ok) |=> $stable(prev_state))
    else $error("previous state moved");
  chk_off_invalid: assert property (!standby_rail_ok |=> !prev_state_valid)
    else $error("valid while rail down");
  chk_rd_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  chk_resp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  cover property ($rose(standby_rail_ok) && fell);
  cover property (s_axi_rvalid && rd_sel);
  cover property (s_axi_bvalid && s_axi_bresp == 2'h2);
endmodule // psps_sampler_monitor

bind psps_sampler psps_sampler_monitor #(.ADDR_W(ADDR_W)) u_mon (.aclk, .aresetn,
  .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_bvalid,
  .s_axi_bready, .s_axi_bresp, .standby_rail_ok, .prev_state, .prev_state_valid);

// ===== test/psps_supply_model.sv
// Model of the supply-on request pin and the two supply rails.
`timescale 1ns/1ps
module psps_supply_model (
  // Clock and rail commands
  input  wire aclk,
  input  wire stby_on,
  input  wire main_on,
  // Pin and rails
  output reg  pin             = 1'b0,
  output reg  standby_rail_ok = 1'b1,
  output reg  main_rail_ok    = 1'b0
);
  // The pin period is off the tick so history entries differ.
  reg [4:0] cnt = 5'h00;
  always @(posedge aclk) begin
    cnt             <= cnt + 5'h01;
    pin             <= cnt[4] ^ cnt[2];
    standby_rail_ok <= stby_on;
    main_rail_ok    <= main_on;
  end
endmodule // psps_supply_model

// ===== test/psps_sampler_tb.sv
// Self-checking bench for the previous state sampler.
`timescale 1ns/1ps
module psps_sampler_tb;
  localparam logic [11:0] SEL = 12'h14C;
  localparam logic [11:0] STAT = 12'h1C0;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [11:0] s_axi_awaddr = 12'h000;
  logic [11:0] s_axi_araddr = 12'h000;
  logic [31:0] s_axi_wdata = 32'h0;
  logic s_axi_awvalid = 1'b0;
  logic s_axi_wvalid = 1'b0;
  logic s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0;
  logic s_axi_rready = 1'b0;
  logic stby_on = 1'b1;
  logic main_on = 1'b0;
  wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire [1:0] s_axi_bresp, s_axi_rresp;
  wire [31:0] s_axi_rdata;
  wire supply_on_request_pin, standby_rail_ok, main_rail_ok, prev_state, prev_state_valid;
  int n_errors = 0;
  int total_checks = 0;
  int cyc = 0;
  logic [31:0] d;
  logic [31:0] h;
  logic [1:0] r;

  psps_sampler #(.HALF_SEC_CYCLES(8), .ADDR_W(12)) u_dut (.aclk, .aresetn,
    .s_axi_awaddr, .s_axi_awprot(3'h0), .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb(4'hF), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arprot(3'h0), .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .supply_on_request_pin,
    .standby_rail_ok, .main_rail_ok, .prev_state, .prev_state_valid);
  psps_supply_model u_model (.aclk, .stby_on, .main_on, .pin(supply_on_request_pin),
    .standby_rail_ok, .main_rail_ok);

  task give_verdict;
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask
  task wr(input logic [11:0] a, input logic [31:0] v);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
    r = s_axi_bresp;
  endtask
  task rd(input logic [11:0] a);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    s_axi_rready <= 1'b0;
    d = s_axi_rdata;
    r = s_axi_rresp;
  endtask
  task t_regs;
    rd(SEL);
    chk("select reset", 32'h0, d);
    rd(STAT);
    chk("history reset", 32'h0, d & 32'hFF);
    wr(SEL, 32'hF7);
    rd(SEL);
    chk("select upper", 32'h7, d);
    wr(SEL, 32'h0);
    rd(12'h000);
    chk("bad read", 32'h2, {30'h0, r});
    wr(12'h004, 32'h1);
    chk("bad write", 32'h2, {30'h0, r});
  endtask
  task t_hold;
    main_on <= 1'b1;
    repeat (60) @(posedge aclk);
    main_on <= 1'b0;
    repeat (4) @(posedge aclk);
    rd(STAT);
    h = d;
    chk("sampled", 32'h1, {31'h0, h[7:0] != 8'h00});
    repeat (40) @(posedge aclk);
    rd(STAT);
    chk("held", h & 32'hFF, d & 32'hFF);
    // Twelve cycles with both rails up fit exactly one capture at this period.
    main_on <= 1'b1;
    repeat (12) @(posedge aclk);
    main_on <= 1'b0;
    repeat (4) @(posedge aclk);
    rd(STAT);
    chk("shifted", {25'h0, h[6:0]}, {25'h0, d[7:1]});
  endtask
  task t_clear;
    rd(STAT);
    chk("fail set", 32'h1, {31'h0, d[11]});
    wr(STAT, 32'h800);
    chk("stat write", 32'h0, {30'h0, r});
    rd(STAT);
    chk("fail cleared", 32'h0, {31'h0, d[11]});
  endtask
  task t_recover(input logic [2:0] n);
    wr(SEL, {29'h0, n});
    main_on <= 1'b1;
    repeat (80) @(posedge aclk);
    main_on <= 1'b0;
    repeat (4) @(posedge aclk);
    rd(STAT);
    h = d;
    stby_on <= 1'b0;
    repeat (6) @(posedge aclk);
    rd(STAT);
    chk("frozen", {31'h0, h[n]}, {31'h0, d[10]});
    chk("valid down", 32'h0, {31'h0, prev_state_valid});
    stby_on <= 1'b1;
    repeat (4) @(posedge aclk);
    chk("prev", {31'h0, h[n]}, {31'h0, prev_state});
    chk("valid up", 32'h1, {31'h0, prev_state_valid});
  endtask

  initial forever #2 aclk = ~aclk;
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_errors++;
      give_verdict;
    end
  end
  initial begin
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    t_regs;
    t_hold;
    for (int n = 0; n < 8; n++) t_recover(n[2:0]);
    t_clear;
    give_verdict;
  end
endmodule // psps_sampler_tb
